/* verilog/bcr_pkg.sv */
// package for the boot record command engine: framing, command and answer codes, timing
// assumes a 40 MHz system clock and a byte transport on the same clock
package bcr_pkg;
	localparam logic [7:0] FRAME_START = 8'h24;
	localparam logic [7:0] CMD_IDENT = 8'h30;
	localparam logic [7:0] CMD_SETUP = 8'h31;
	localparam logic [7:0] CMD_ERASE = 8'h32;
	localparam logic [7:0] CMD_WRITE = 8'h33;
	localparam logic [7:0] CMD_VERIFY = 8'h34;
	localparam logic [7:0] CMD_LOCK = 8'h35;
	localparam logic [7:0] CMD_RUN = 8'h36;
	localparam logic [7:0] RESP_ACK = 8'h40;
	localparam logic [7:0] RESP_RANGE = 8'h41;
	localparam logic [7:0] RESP_ID_MISMATCH_ERROR = 8'h42;
	localparam logic [7:0] RESP_CRC = 8'h43;
	localparam logic [7:0] VERSION_CODE = 8'h90;
	localparam logic [15:0] FLASH_KEY = 16'ha5f1;
	localparam logic [7:0] BANK_SCRATCH = 8'h01;
	localparam logic [7:0] KEEP_BYTE = 8'hff;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	localparam logic [7:0] LEN_IDENT = 8'h03;
	localparam logic [7:0] LEN_SETUP = 8'h04;
	localparam logic [7:0] LEN_VERIFY = 8'h07;
	localparam logic [7:0] LEN_LOCK = 8'h03;
	localparam logic [7:0] LEN_RUN = 8'h03;
	localparam logic [7:0] LEN_ERASE_MIN = 8'h03;
	localparam logic [7:0] LEN_WRITE_MIN = 8'h04;
	localparam logic [7:0] LEN_MAX = 8'h83;
	localparam logic [7:0] DATA_OFFSET = 8'h02;
	localparam int HDR_N = 6;
	localparam int MAX_DATA = 128;
	localparam int CLK_HZ = 40_000_000;
	localparam int RUN_DELAY_MS = 100;
	localparam int RUN_DELAY_CYCLES = (CLK_HZ / 1000) * RUN_DELAY_MS;
	localparam int FOP_W = 2;
	localparam logic [FOP_W-1:0] FOP_READ = 2'h0;
	localparam logic [FOP_W-1:0] FOP_ERASE = 2'h1;
	localparam logic [FOP_W-1:0] FOP_WRITE = 2'h2;
	typedef enum logic [3:0] {
		ST_SYNC, ST_LEN, ST_CMD, ST_PAY, ST_EXEC, ST_FETCH, ST_LOAD, ST_FLASH, ST_RESP, ST_DRAIN, ST_RUN
	} bcr_state_t;
endpackage

/* verilog/bcr_mem.sv */
// payload store: one write port, one read port whose data come from a register
// assumes a single clock; read data appear one edge after the address
`timescale 1ns/1ps
module bcr_mem #(
	parameter int W = 8,
	parameter int DEPTH = 128,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [W-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [W-1:0] rdata_o
);
	logic [W-1:0] mem [DEPTH];
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule // bcr_mem

/* verilog/bcr_buf.sv */
// two-entry buffer with valid and ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module bcr_buf #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	logic [W-1:0] d0_reg, d0_next, d1_reg, d1_next;
	logic [1:0] cnt_reg, cnt_next;
	logic put, take;
	assign in_ready_o = (cnt_reg != 2'h2);
	assign out_valid_o = (cnt_reg != 2'h0);
	assign out_data_o = d0_reg;
	always_comb begin
		put = in_valid_i && in_ready_o;
		take = out_valid_o && out_ready_i;
		d0_next = d0_reg;
		d1_next = d1_reg;
		cnt_next = cnt_reg + {1'b0, put} - {1'b0, take};
		if (take) begin
			d0_next = (cnt_reg == 2'h2) ? d1_reg : in_data_i;
		end
		if (put) begin
			if (cnt_reg == 2'h0 || (cnt_reg == 2'h1 && take)) begin
				d0_next = in_data_i;
			end else begin
				d1_next = in_data_i;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			d0_reg <= '0;
			d1_reg <= '0;
			cnt_reg <= 2'h0;
		end else begin
			d0_reg <= d0_next;
			d1_reg <= d1_next;
			cnt_reg <= cnt_next;
		end
	end
endmodule // bcr_buf

/* verilog/bcr_engine.sv */
// boot record command engine: framed records in, one answer byte out, flash steered by ports
// assumes byte transport, flash controller and reset logic run on CLOCK_I
//
// Notes on behaviour
// - one answer byte after each processed record
// - commands return no data, only codes
// - record may arrive in pieces, reassembled
// - next record waits until answer read
// - slow answers only for erase, write and verify
// - sixteen-bit fields travel high byte first
// - unknown command answers version byte
// - identify answers ack or id mismatch
// - setup carries keys and bank, acked
// - bank one selects scratchpad where present
// - erase page at address, then write data
// - write programs data without erasing first
// - unwritable range answers range error
// - verify compares xmodem crc over range
// - lock writes signature and lock bytes
// - run application acks, then resets device
// - record lengths fixed per command, except erase and write
`timescale 1ns/1ps
module bcr_engine #(
	parameter logic [7:0] PART_CODE = 8'h01, // arbitrary value
	parameter logic [7:0] VARIANT_CODE = 8'h02, // arbitrary value
	parameter bit HAS_SCRATCHPAD = 1'b0,
	parameter bit USB_VARIANT = 1'b0,
	parameter int RUN_DELAY_CYCLES = bcr_pkg::RUN_DELAY_CYCLES,
	parameter int DATA_DEPTH = bcr_pkg::MAX_DATA
) (
	input wire logic CLOCK_I,
	input wire logic RESET_N_I,
	input wire logic [7:0] RX_DATA_I,
	input wire logic RX_VALID_I,
	output logic RX_READY_O,
	output logic [7:0] RESP_DATA_O,
	output logic RESP_VALID_O,
	input wire logic RESP_READY_I,
	output logic FLASH_REQ_O,
	output logic [bcr_pkg::FOP_W-1:0] FLASH_OP_O,
	output logic [15:0] FLASH_ADDR_O,
	output logic [7:0] FLASH_WDATA_O,
	output logic FLASH_BANK_O,
	output logic [15:0] FLASH_KEYS_O,
	input wire logic FLASH_ACK_I,
	input wire logic [7:0] FLASH_RDATA_I,
	input wire logic [15:0] FLASH_LIMIT_I,
	output logic SIG_WE_O,
	output logic [7:0] SIG_DATA_O,
	output logic LOCK_WE_O,
	output logic [7:0] LOCK_DATA_O,
	output logic APP_RESET_O
);
	import bcr_pkg::*;

	localparam int AW = $clog2(DATA_DEPTH);
	localparam int RUN_WAIT = USB_VARIANT ? RUN_DELAY_CYCLES : 1;

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
		end
		return r;
	endfunction

	function automatic logic is_known(input logic [7:0] c);
		return c >= CMD_IDENT && c <= CMD_RUN;
	endfunction

	function automatic logic len_ok(input logic [7:0] c, input logic [7:0] l);
		logic ok;
		ok = 1'b0;
		unique case (c)
			CMD_IDENT: ok = (l == LEN_IDENT);
			CMD_SETUP: ok = (l == LEN_SETUP);
			CMD_ERASE: ok = (l >= LEN_ERASE_MIN) && (l <= LEN_MAX);
			CMD_WRITE: ok = (l >= LEN_WRITE_MIN) && (l <= LEN_MAX);
			CMD_VERIFY: ok = (l == LEN_VERIFY);
			CMD_LOCK: ok = (l == LEN_LOCK);
			CMD_RUN: ok = (l == LEN_RUN);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	bcr_state_t state_reg, state_next;
	logic [7:0] len_reg, len_next;
	logic [7:0] idx_reg, idx_next;
	logic [7:0] cmd_reg, cmd_next;
	logic [7:0] hdr_reg [HDR_N];
	logic [7:0] hdr_next [HDR_N];
	logic [7:0] resp_reg, resp_next;
	logic [7:0] wcnt_reg, wcnt_next;
	logic [15:0] crc_reg, crc_next;
	logic [15:0] keys_reg, keys_next;
	logic bank_reg, bank_next;
	logic setup_reg, setup_next;
	logic freq_reg, freq_next;
	logic [FOP_W-1:0] fop_reg, fop_next;
	logic [15:0] faddr_reg, faddr_next;
	logic [7:0] fwdata_reg, fwdata_next;
	logic sig_we_reg, sig_we_next;
	logic lock_we_reg, lock_we_next;
	logic [7:0] sig_reg, sig_next;
	logic [7:0] lock_reg, lock_next;
	logic app_reset_reg, app_reset_next;
	logic [31:0] run_reg, run_next;
	logic push, buf_in_ready;
	logic mem_we;
	logic [AW-1:0] mem_waddr;
	logic [7:0] mem_rdata;
	logic [15:0] base_addr, vend_addr, crc_n;
	logic [7:0] ndata;
	logic [16:0] span_end;
	logic range_ok;

	// sixteen-bit fields are assembled high byte first
	assign base_addr = {hdr_reg[0], hdr_reg[1]};
	assign vend_addr = {hdr_reg[2], hdr_reg[3]};
	assign ndata = len_reg - LEN_ERASE_MIN;
	assign crc_n = crc_byte(crc_reg, FLASH_RDATA_I);
	assign mem_waddr = AW'(idx_reg - DATA_OFFSET);
	assign span_end = {1'b0, base_addr} + {9'h000, ndata} - {16'h0000, ndata != 8'h00};
	// every byte of the target span must sit below the writable limit, and keys must be set
	assign range_ok = setup_reg && (keys_reg == FLASH_KEY) && (span_end < {1'b0, FLASH_LIMIT_I});

	assign RX_READY_O = (state_reg == ST_SYNC) || (state_reg == ST_LEN)
		|| (state_reg == ST_CMD) || (state_reg == ST_PAY);
	assign FLASH_REQ_O = freq_reg;
	assign FLASH_OP_O = fop_reg;
	assign FLASH_ADDR_O = faddr_reg;
	assign FLASH_WDATA_O = fwdata_reg;
	assign FLASH_BANK_O = bank_reg;
	assign FLASH_KEYS_O = keys_reg;
	assign SIG_WE_O = sig_we_reg;
	assign SIG_DATA_O = sig_reg;
	assign LOCK_WE_O = lock_we_reg;
	assign LOCK_DATA_O = lock_reg;
	assign APP_RESET_O = app_reset_reg;

	always_comb begin
		state_next = state_reg;
		len_next = len_reg;
		idx_next = idx_reg;
		cmd_next = cmd_reg;
		hdr_next = hdr_reg;
		resp_next = resp_reg;
		wcnt_next = wcnt_reg;
		crc_next = crc_reg;
		keys_next = keys_reg;
		bank_next = bank_reg;
		setup_next = setup_reg;
		freq_next = freq_reg;
		fop_next = fop_reg;
		faddr_next = faddr_reg;
		fwdata_next = fwdata_reg;
		sig_we_next = 1'b0;
		lock_we_next = 1'b0;
		sig_next = sig_reg;
		lock_next = lock_reg;
		app_reset_next = 1'b0;
		run_next = run_reg;
		push = 1'b0;
		mem_we = 1'b0;
		unique case (state_reg)
			ST_SYNC: begin
				if (RX_VALID_I && RX_DATA_I == FRAME_START) begin
					state_next = ST_LEN;
				end
			end
			ST_LEN: begin
				if (RX_VALID_I) begin
					len_next = RX_DATA_I;
					idx_next = 8'h00;
					state_next = (RX_DATA_I == 8'h00) ? ST_SYNC : ST_CMD;
				end
			end
			ST_CMD: begin
				if (RX_VALID_I) begin
					cmd_next = RX_DATA_I;
					state_next = (len_reg == 8'h01) ? ST_EXEC : ST_PAY;
				end
			end
			ST_PAY: begin
				// bytes are counted, not packets, so split transfers reassemble
				if (RX_VALID_I) begin
					if (idx_reg < 8'(HDR_N)) begin
						hdr_next[idx_reg[2:0]] = RX_DATA_I;
					end
					mem_we = (idx_reg >= DATA_OFFSET) && (idx_reg < 8'(DATA_DEPTH) + DATA_OFFSET);
					idx_next = idx_reg + 8'h01;
					if (8'(idx_reg + DATA_OFFSET) == len_reg) begin
						state_next = ST_EXEC;
					end
				end
			end
			ST_EXEC: begin
				wcnt_next = 8'h00;
				crc_next = CRC_INIT;
				resp_next = RESP_ACK;
				state_next = ST_RESP;
				if (!len_ok(cmd_reg, len_reg)) begin
					resp_next = VERSION_CODE;
				end else begin
					unique case (cmd_reg)
						CMD_IDENT: begin
							resp_next = (base_addr == {PART_CODE, VARIANT_CODE}) ? RESP_ACK : RESP_ID_MISMATCH_ERROR;
						end
						CMD_SETUP: begin
							keys_next = base_addr;
							setup_next = 1'b1;
							bank_next = HAS_SCRATCHPAD && (hdr_reg[2] == BANK_SCRATCH);
						end
						CMD_ERASE, CMD_WRITE: begin
							if (!range_ok) begin
								resp_next = RESP_RANGE;
							end else if (cmd_reg == CMD_ERASE) begin
								faddr_next = base_addr;
								fop_next = FOP_ERASE;
								freq_next = 1'b1;
								state_next = ST_FLASH;
							end else begin
								state_next = ST_FETCH;
							end
						end
						CMD_VERIFY: begin
							faddr_next = base_addr;
							fop_next = FOP_READ;
							freq_next = 1'b1;
							state_next = ST_FLASH;
						end
						CMD_LOCK: begin
							sig_we_next = (hdr_reg[0] != KEEP_BYTE);
							lock_we_next = (hdr_reg[1] != KEEP_BYTE);
							sig_next = hdr_reg[0];
							lock_next = hdr_reg[1];
						end
						CMD_RUN: begin
							resp_next = RESP_ACK;
						end
						default: begin
							resp_next = VERSION_CODE;
						end
					endcase
				end
			end
			ST_FETCH: begin
				state_next = ST_LOAD;
			end
			ST_LOAD: begin
				fwdata_next = mem_rdata;
				faddr_next = 16'(base_addr + {8'h00, wcnt_reg});
				fop_next = FOP_WRITE;
				freq_next = 1'b1;
				state_next = ST_FLASH;
			end
			ST_FLASH: begin
				if (FLASH_ACK_I) begin
					freq_next = 1'b0;
					unique case (fop_reg)
						FOP_ERASE: begin
							state_next = (ndata == 8'h00) ? ST_RESP : ST_FETCH;
						end
						FOP_WRITE: begin
							wcnt_next = wcnt_reg + 8'h01;
							state_next = (wcnt_next == ndata) ? ST_RESP : ST_FETCH;
						end
						FOP_READ: begin
							crc_next = crc_n;
							if (faddr_reg == vend_addr) begin
								resp_next = (crc_n == {hdr_reg[4], hdr_reg[5]}) ? RESP_ACK : RESP_CRC;
								state_next = ST_RESP;
							end else begin
								faddr_next = faddr_reg + 16'h0001;
								freq_next = 1'b1;
							end
						end
						default: begin
							state_next = ST_RESP;
						end
					endcase
				end
			end
			ST_RESP: begin
				// a single code byte, offered as soon as the command is done
				push = 1'b1;
				if (buf_in_ready) begin
					state_next = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				// the next record waits until the answer has been taken
				if (!RESP_VALID_O) begin
					run_next = 32'h0000_0000;
					state_next = (cmd_reg == CMD_RUN && resp_reg == RESP_ACK) ? ST_RUN : ST_SYNC;
				end
			end
			ST_RUN: begin
				run_next = run_reg + 32'h0000_0001;
				if (run_reg == 32'(RUN_WAIT - 1)) begin
					app_reset_next = 1'b1;
					state_next = ST_SYNC;
				end
			end
			default: begin
				state_next = ST_SYNC;
			end
		endcase
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			state_reg <= ST_SYNC;
			len_reg <= 8'h00;
			idx_reg <= 8'h00;
			cmd_reg <= 8'h00;
			for (int i = 0; i < HDR_N; i++) begin
				hdr_reg[i] <= 8'h00;
			end
			resp_reg <= 8'h00;
			wcnt_reg <= 8'h00;
			crc_reg <= CRC_INIT;
			keys_reg <= 16'h0000;
			bank_reg <= 1'b0;
			setup_reg <= 1'b0;
			freq_reg <= 1'b0;
			fop_reg <= FOP_READ;
			faddr_reg <= 16'h0000;
			fwdata_reg <= 8'h00;
			sig_we_reg <= 1'b0;
			lock_we_reg <= 1'b0;
			sig_reg <= 8'h00;
			lock_reg <= 8'h00;
			app_reset_reg <= 1'b0;
			run_reg <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
			len_reg <= len_next;
			idx_reg <= idx_next;
			cmd_reg <= cmd_next;
			hdr_reg <= hdr_next;
			resp_reg <= resp_next;
			wcnt_reg <= wcnt_next;
			crc_reg <= crc_next;
			keys_reg <= keys_next;
			bank_reg <= bank_next;
			setup_reg <= setup_next;
			freq_reg <= freq_next;
			fop_reg <= fop_next;
			faddr_reg <= faddr_next;
			fwdata_reg <= fwdata_next;
			sig_we_reg <= sig_we_next;
			lock_we_reg <= lock_we_next;
			sig_reg <= sig_next;
			lock_reg <= lock_next;
			app_reset_reg <= app_reset_next;
			run_reg <= run_next;
		end
	end

	bcr_mem #(.W(8), .DEPTH(DATA_DEPTH), .AW(AW)) u_mem (
		.clk_i(CLOCK_I),
		.we_i(mem_we),
		.waddr_i(mem_waddr),
		.wdata_i(RX_DATA_I),
		.raddr_i(wcnt_reg[AW-1:0]),
		.rdata_o(mem_rdata)
	);

	bcr_buf #(.W(8)) u_buf (
		.clk_i(CLOCK_I),
		.rst_n_i(RESET_N_I),
		.in_valid_i(push),
		.in_ready_o(buf_in_ready),
		.in_data_i(resp_reg),
		.out_valid_o(RESP_VALID_O),
		.out_ready_i(RESP_READY_I),
		.out_data_o(RESP_DATA_O)
	);

	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RESET_N_I);

	sequence s_fetch_load;
		state_reg == ST_FETCH ##1 state_reg == ST_LOAD;
	endsequence

	chk_ident_answer: assert property (
		state_reg == ST_EXEC && cmd_reg == CMD_IDENT && len_reg == LEN_IDENT
		|=> state_reg == ST_RESP && resp_reg == ((base_addr == {PART_CODE, VARIANT_CODE}) ? RESP_ACK : RESP_ID_MISMATCH_ERROR))
		else $error("identify answered wrongly");
	chk_unknown_version: assert property (
		state_reg == ST_EXEC && !is_known(cmd_reg) |=> resp_reg == VERSION_CODE && push)
		else $error("unknown command not answered with version");
	chk_one_answer: assert property (
		push && buf_in_ready |=> !push [*2])
		else $error("more than one answer byte per record");
	chk_hold_next_record: assert property (
		RESP_VALID_O |-> !RX_READY_O)
		else $error("record accepted while answer unread");
	chk_range_error: assert property (
		state_reg == ST_EXEC && (cmd_reg == CMD_ERASE || cmd_reg == CMD_WRITE) && len_ok(cmd_reg, len_reg) && !range_ok
		|=> resp_reg == RESP_RANGE && !FLASH_REQ_O)
		else $error("range error not given");
	chk_erase_only_erase: assert property (
		FLASH_REQ_O && FLASH_OP_O == FOP_ERASE |-> cmd_reg == CMD_ERASE)
		else $error("erase issued by other command");
	chk_write_address: assert property (
		s_fetch_load |=> FLASH_REQ_O && FLASH_OP_O == FOP_WRITE && FLASH_ADDR_O == 16'(base_addr + {8'h00, wcnt_reg}))
		else $error("write address wrong");
	chk_crc_compare: assert property (
		state_reg == ST_FLASH && FLASH_ACK_I && fop_reg == FOP_READ && faddr_reg == vend_addr
		|=> resp_reg == (($past(crc_n) == {hdr_reg[4], hdr_reg[5]}) ? RESP_ACK : RESP_CRC))
		else $error("verify result wrong");
	chk_lock_keep: assert property (
		SIG_WE_O || LOCK_WE_O |-> cmd_reg == CMD_LOCK && (!SIG_WE_O || SIG_DATA_O != KEEP_BYTE)
		&& (!LOCK_WE_O || LOCK_DATA_O != KEEP_BYTE))
		else $error("lock byte written with keep value");
	chk_run_reset: assert property (
		APP_RESET_O |-> $past(state_reg) == ST_RUN && cmd_reg == CMD_RUN && resp_reg == RESP_ACK)
		else $error("reset without acked run command");
endmodule // bcr_engine

/* verification/bcr_flash_model.sv */
// flash array behind the engine's flash port, acknowledging after a random wait
// assumes requests hold until the one-cycle acknowledge, all on one clock
`timescale 1ns/1ps
module bcr_flash_model #(
	parameter int PAGE = 512
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_i,
	input wire logic [bcr_pkg::FOP_W-1:0] op_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic ack_o,
	output logic [7:0] rdata_o
);
	import bcr_pkg::*;
	logic [7:0] mem [0:65535];
	integer seed = 32'hd4882751;
	initial begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'hff;
	end
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			ack_o <= 1'b0;
			rdata_o <= 8'h00;
		end else if (ack_o || !req_i || ($random(seed) & 3) != 0) begin
			ack_o <= 1'b0;
			// read data mean nothing away from the acknowledge
			rdata_o <= ~rdata_o;
		end else begin
			ack_o <= 1'b1;
			rdata_o <= mem[addr_i];
			if (op_i == FOP_ERASE)
				for (int i = 0; i < PAGE; i++)
					mem[(int'(addr_i) / PAGE) * PAGE + i] = 8'hff;
			if (op_i == FOP_WRITE)
				mem[addr_i] = mem[addr_i] & wdata_i;
		end
	end
endmodule // bcr_flash_model

/* verification/tb.sv */
// self-checking bench for the boot record engine, with a reference model of flash and answers
// assumes the flash model above on the flash port; host and answer reader are played here
`timescale 1ns/1ps
module tb;
	import bcr_pkg::*;
	localparam int PAGE = 512;
	localparam logic [7:0] PART = 8'h5a; // arbitrary value
	localparam logic [7:0] VARIANT = 8'hc3; // arbitrary value
	logic clk = 1'b0, rst_n = 1'b0, rx_valid = 1'b0, resp_ready = 1'b0, keys_ok = 1'b0;
	logic [7:0] rx_data = 8'h00;
	logic [15:0] limit = 16'h0400;
	logic rx_ready, resp_valid, f_req, f_ack, f_bank, sig_we, lock_we, app_reset;
	logic [7:0] resp_data, f_wdata, f_rdata, sig_data, lock_data, r;
	logic [7:0] last_sig = 8'h00, last_lock = 8'h00, exp_sig = 8'h00, exp_lock = 8'h00;
	logic [FOP_W-1:0] f_op;
	logic [15:0] f_addr, f_keys, c;
	logic [7:0] ref_mem [0:65535];
	logic [7:0] pay [$];
	int n_errors = 0, samples_checked = 0, n_sig = 0, n_lock = 0, n_app = 0, s0, l0;
	integer seed = 32'hd4882751;
	logic [7:0] sigv [3] = '{8'ha5, 8'hff, 8'h00};
	logic [7:0] lockv [3] = '{8'hff, 8'h3c, 8'h00};

	always #12.5 clk = ~clk;

	bcr_engine #(.PART_CODE(PART), .VARIANT_CODE(VARIANT), .HAS_SCRATCHPAD(1'b1), .USB_VARIANT(1'b0),
		.RUN_DELAY_CYCLES(10), .DATA_DEPTH(MAX_DATA)) dut (.CLOCK_I(clk), .RESET_N_I(rst_n),
		.RX_DATA_I(rx_data), .RX_VALID_I(rx_valid), .RX_READY_O(rx_ready), .RESP_DATA_O(resp_data),
		.RESP_VALID_O(resp_valid), .RESP_READY_I(resp_ready), .FLASH_REQ_O(f_req), .FLASH_OP_O(f_op),
		.FLASH_ADDR_O(f_addr), .FLASH_WDATA_O(f_wdata), .FLASH_BANK_O(f_bank), .FLASH_KEYS_O(f_keys),
		.FLASH_ACK_I(f_ack), .FLASH_RDATA_I(f_rdata), .FLASH_LIMIT_I(limit), .SIG_WE_O(sig_we),
		.SIG_DATA_O(sig_data), .LOCK_WE_O(lock_we), .LOCK_DATA_O(lock_data), .APP_RESET_O(app_reset));

	bcr_flash_model #(.PAGE(PAGE)) flash (.clk_i(clk), .rst_n_i(rst_n), .req_i(f_req), .op_i(f_op),
		.addr_i(f_addr), .wdata_i(f_wdata), .ack_o(f_ack), .rdata_o(f_rdata));

	always @(posedge clk) begin
		if (sig_we === 1'b1) begin
			n_sig++;
			last_sig = sig_data;
		end
		if (lock_we === 1'b1) begin
			n_lock++;
			last_lock = lock_data;
		end
		if (app_reset === 1'b1)
			n_app++;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic timeout();
		n_errors++;
		$display("mismatch at %0t: wait bound used up", $time);
		print_verdict();
	endtask

	// valid stays up between bytes; pauses split the record into pieces
	task automatic send_byte(input logic [7:0] b);
		int i;
		if (($random(seed) & 3) == 0) begin
			rx_valid = 1'b0;
			repeat (2) @(negedge clk);
		end
		rx_data = b;
		rx_valid = 1'b1;
		for (i = 0; i < 1000 && rx_ready !== 1'b1; i++)
			@(negedge clk);
		if (i == 1000)
			timeout();
		@(negedge clk);
	endtask

	task automatic send_rec(input logic [7:0] len, input logic [7:0] cmd);
		send_byte(8'h11);
		send_byte(FRAME_START);
		send_byte(len);
		send_byte(cmd);
		foreach (pay[k])
			send_byte(pay[k]);
		rx_valid = 1'b0; // one record, then wait for its answer
	endtask

	task automatic get_resp(output logic [7:0] rv);
		int i;
		for (i = 0; i < 20000 && resp_valid !== 1'b1; i++)
			@(negedge clk);
		if (i == 20000)
			timeout();
		check(rx_ready, 1'b0);
		repeat ($random(seed) & 3) @(negedge clk);
		rv = resp_data;
		resp_ready = 1'b1;
		@(negedge clk);
		resp_ready = 1'b0;
		check(resp_valid, 1'b0);
	endtask

	function automatic logic [15:0] crc_of(input logic [15:0] a1, input logic [15:0] a2);
		logic [15:0] cr;
		cr = CRC_INIT;
		for (int n = 0; n < 65536; n++) begin
			cr = cr ^ {ref_mem[16'(a1 + n)], 8'h00};
			for (int b = 0; b < 8; b++)
				cr = cr[15] ? {cr[14:0], 1'b0} ^ CRC_POLY : {cr[14:0], 1'b0};
			if (16'(a1 + n) == a2)
				break;
		end
		return cr;
	endfunction

	task automatic set_pay(input logic [15:0] a, input int n);
		pay = '{a[15:8], a[7:0]};
		repeat (n) pay.push_back(8'($random(seed)));
	endtask

	task automatic run_rec(input logic [7:0] cmd);
		logic [7:0] exp;
		logic [15:0] a;
		int n, last;
		n = pay.size();
		a = {pay[0], pay[1]};
		exp = VERSION_CODE;
		case (cmd)
			CMD_IDENT: if (n == 2) exp = (a == {PART, VARIANT}) ? RESP_ACK : RESP_ID_MISMATCH_ERROR;
			CMD_SETUP: if (n == 3) begin
				exp = RESP_ACK;
				keys_ok = (a == FLASH_KEY);
			end
			CMD_ERASE, CMD_WRITE: if (n >= ((cmd == CMD_ERASE) ? 2 : 3) && n <= 130) begin
				last = (n == 2) ? a : a + n - 3;
				exp = (!keys_ok || last >= limit) ? RESP_RANGE : RESP_ACK;
				if (exp == RESP_ACK && cmd == CMD_ERASE)
					for (int i = 0; i < PAGE; i++)
						ref_mem[(int'(a) / PAGE) * PAGE + i] = 8'hff;
				if (exp == RESP_ACK)
					for (int k = 2; k < n; k++)
						ref_mem[16'(a + k - 2)] &= pay[k];
			end
			CMD_VERIFY: if (n == 6)
				exp = (crc_of(a, {pay[2], pay[3]}) == {pay[4], pay[5]}) ? RESP_ACK : RESP_CRC;
			CMD_LOCK, CMD_RUN: if (n == 2) exp = RESP_ACK;
			default: ;
		endcase
		send_rec(8'(n + 1), cmd);
		get_resp(r);
		check(r, exp);
	endtask

	task automatic verify(input logic [15:0] a1, input logic [15:0] a2, input logic [15:0] flip);
		c = crc_of(a1, a2) ^ flip;
		pay = '{a1[15:8], a1[7:0], a2[15:8], a2[7:0], c[15:8], c[7:0]};
		run_rec(CMD_VERIFY);
	endtask

	initial begin
		for (int i = 0; i < 65536; i++)
			ref_mem[i] = 8'hff;
		repeat (20) @(negedge clk);
		check({rx_ready, resp_valid, f_req, f_keys}, 19'h40000);
		rst_n = 1'b1;
		@(negedge clk);
		send_byte(FRAME_START);
		send_byte(8'h00);
		rx_valid = 1'b0;
		repeat (10) @(negedge clk);
		check(resp_valid, 1'b0);
		$display("test framing done");
		pay = '{PART, VARIANT};
		run_rec(CMD_IDENT);
		pay = '{PART, 8'h00};
		run_rec(CMD_IDENT);
		pay = '{PART, VARIANT, 8'h00};
		run_rec(CMD_IDENT);
		pay = '{8'h00, 8'h00};
		run_rec(8'h3f);
		set_pay(16'h0200, 0);
		run_rec(CMD_ERASE);
		pay = '{8'h12, 8'h34, 8'h00};
		run_rec(CMD_SETUP);
		set_pay(16'h0200, 1);
		run_rec(CMD_WRITE);
		$display("test identify and keys done");
		pay = '{8'ha5, 8'hf1, BANK_SCRATCH};
		run_rec(CMD_SETUP);
		check({f_bank, f_keys}, 17'h1a5f1);
		pay = '{8'ha5, 8'hf1, 8'h00};
		run_rec(CMD_SETUP);
		check(f_bank, 1'b0);
		$display("test setup done");
		set_pay(16'h0200, 4);
		run_rec(CMD_ERASE);
		set_pay(16'h0204, 16);
		run_rec(CMD_WRITE);
		set_pay(16'h0206, 2);
		run_rec(CMD_WRITE);
		set_pay(16'h0300, MAX_DATA);
		run_rec(CMD_WRITE);
		set_pay(16'h03fe, 2);
		run_rec(CMD_WRITE);
		set_pay(16'h03fe, 3);
		run_rec(CMD_WRITE);
		set_pay(16'h0400, 0);
		run_rec(CMD_ERASE);
		for (int i = 0; i < 6; i++) begin
			set_pay(16'h0100 + 16'($random(seed) & 16'h00f0), 1 + ($random(seed) & 15));
			run_rec(CMD_WRITE);
		end
		verify(16'h0100, 16'h03ff, 16'h0000);
		verify(16'h0200, 16'h0213, 16'h0001);
		verify(16'h0206, 16'h0206, 16'h0000);
		$display("test flash and verify done");
		for (int i = 0; i < 3; i++) begin
			s0 = n_sig;
			l0 = n_lock;
			pay = '{sigv[i], lockv[i]};
			if (sigv[i] != KEEP_BYTE)
				exp_sig = sigv[i];
			if (lockv[i] != KEEP_BYTE)
				exp_lock = lockv[i];
			run_rec(CMD_LOCK);
			check(16'(n_sig - s0), 16'(sigv[i] != KEEP_BYTE));
			check(16'(n_lock - l0), 16'(lockv[i] != KEEP_BYTE));
			check({last_sig, last_lock}, {exp_sig, exp_lock});
		end
		$display("test lock done");
		s0 = n_app;
		pay = '{8'h00, 8'h00};
		send_rec(8'h03, CMD_RUN);
		repeat (20) @(negedge clk);
		check(16'(n_app - s0), 16'h0000);
		get_resp(r);
		check(r, RESP_ACK);
		repeat (20) @(negedge clk);
		check(16'(n_app - s0), 16'h0001);
		$display("test run application done");
		print_verdict();
	end
endmodule // tb
